// >>> hdl/dram_host_pkg.sv
// Package with timing, layout and type definitions for the asynchronous DRAM module controller.
package dram_host_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Least times round up, longest times round down, never below one cycle.
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic logic [13:0] sat_inc(input logic [13:0] v);
    return (&v) ? v : v + 14'h0001;
  endfunction

  // Slower-grade figures are used throughout so one build serves both grades.
  localparam int T_RC_NS   = 130;
  localparam int T_RP_NS   = 50;
  localparam int T_RAS_NS  = 70;
  localparam int T_CP_NS   = 10;
  localparam int T_CAS_NS  = 20;
  localparam int T_RAH_NS  = 10;
  localparam int ROW_TO_COL_DELAY_NS  = 20;
  localparam int T_PC_NS   = 45;
  localparam int ROW_HOLD_AFTER_COL_PRECHARGE_NS = 40;
  localparam int COL_HOLD_AFTER_ROW_NS  = 15;
  localparam int ROW_ACCESS_TIME_NS  = 70;
  localparam int COL_ACCESS_TIME_NS  = 20;
  localparam int T_AA_NS   = 35;
  localparam int COL_PRECHARGE_ACCESS_TIME_NS  = 40;
  localparam int T_OFF_NS  = 20;
  localparam int WRITE_HOLD_FROM_ROW_NS  = 55;
  localparam int DATA_HOLD_FROM_ROW_NS  = 55;
  localparam int T_WCH_NS  = 15;
  localparam int T_DH_NS   = 15;
  localparam int PAGE_ROW_PULSE_WIDTH_MAX_NS = 100000;
  localparam int REF_PERIOD_MS = 16;
  localparam int REF_ROWS      = 1024;
  localparam int INIT_PAUSE_US = 100;
  localparam int SYNC_STAGES   = 2;

  localparam logic [13:0] RC_CYC   = 14'(cyc_min(T_RC_NS));
  localparam logic [13:0] RP_CYC   = 14'(cyc_min(T_RP_NS));
  localparam logic [13:0] RAS_CYC  = 14'(cyc_min(T_RAS_NS));
  localparam logic [13:0] CP_CYC   = 14'(cyc_min(T_CP_NS));
  localparam logic [13:0] CAS_CYC  = 14'(cyc_min(T_CAS_NS));
  localparam logic [13:0] RAH_CYC  = 14'(cyc_min(T_RAH_NS));
  localparam logic [13:0] RCD_CYC  = 14'(cyc_min(ROW_TO_COL_DELAY_NS));
  localparam logic [13:0] PC_CYC   = 14'(cyc_min(T_PC_NS));
  localparam logic [13:0] CPRH_CYC = 14'(cyc_min(ROW_HOLD_AFTER_COL_PRECHARGE_NS));
  localparam logic [13:0] CHR_CYC  = 14'(cyc_min(COL_HOLD_AFTER_ROW_NS));
  localparam logic [13:0] RAC_CYC  = 14'(cyc_min(ROW_ACCESS_TIME_NS));
  localparam logic [13:0] CAC_CYC  = 14'(cyc_min(COL_ACCESS_TIME_NS));
  localparam logic [13:0] AA_CYC   = 14'(cyc_min(T_AA_NS));
  localparam logic [13:0] CPA_CYC  = 14'(cyc_min(COL_PRECHARGE_ACCESS_TIME_NS));
  localparam logic [13:0] OFF_CYC  = 14'(cyc_min(T_OFF_NS));
  localparam logic [13:0] WCR_CYC  = 14'(cyc_min(WRITE_HOLD_FROM_ROW_NS));
  localparam logic [13:0] DHR_CYC  = 14'(cyc_min(DATA_HOLD_FROM_ROW_NS));
  localparam logic [13:0] WCH_CYC  = 14'(cyc_min(T_WCH_NS));
  localparam logic [13:0] DH_CYC   = 14'(cyc_min(T_DH_NS));
  localparam logic [13:0] REF_INT_CYC = 14'(cyc_max(REF_PERIOD_MS * 1000000 / REF_ROWS));
  localparam logic [13:0] DATA_LAT    = 14'(SYNC_STAGES + 1);
  localparam logic [13:0] PAGE_MARGIN_CYC = 14'h0040;
  localparam int INIT_PAUSE_CYC    = cyc_min(INIT_PAUSE_US * 1000);
  localparam int RASP_MAX_CYC_DFLT = cyc_max(PAGE_ROW_PULSE_WIDTH_MAX_NS);

  localparam logic [3:0] INIT_REFRESHES = 4'h8;
  localparam logic [3:0] OWED_MAX       = 4'hf;
  localparam logic [3:0] STROBES_OFF    = 4'hf;
  localparam logic [3:0] BANK0_RAS_N    = 4'ha;
  localparam logic [3:0] BANK1_RAS_N    = 4'h5;
  localparam int         LANE_W         = 9;
  localparam int         PD_GRADE_BIT   = 2;

  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_REF, ST_ROW, ST_COL, ST_PRE, ST_RP} state_e;

  typedef struct packed {
    logic        write;
    logic        bank;
    logic [9:0]  row;
    logic [9:0]  col;
    logic [3:0]  byte_en;
    logic [35:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic [3:0]  row_strobe_n;
    logic [3:0]  column_strobe_n;
    logic        write_n;
    logic [9:0]  addr;
    logic [35:0] dq;
    logic        dq_oe_n;
  } dram_pins_s;

endpackage

// >>> hdl/sync2.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             en_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q;
  } sync_s;

  sync_s s;
  sync_s next_s;

  always_comb begin
    next_s      = s;
    next_s.meta = d_i;
    next_s.q    = s.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else if (en_i) begin
      s <= next_s;
    end
  end

  assign q_o = s.q;
endmodule

// >>> hdl/refresh_timer.sv
// Interval timer that requests one refresh per distributed refresh slot.
`timescale 1ns/1ps
module refresh_timer (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  output logic      tick_o
);
  import dram_host_pkg::*;

  typedef struct packed {
    logic [13:0] cnt;
    logic        tick;
  } timer_s;

  timer_s s;
  timer_s next_s;

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (s.cnt >= REF_INT_CYC - 14'h0001) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 14'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else if (en_i) begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;
endmodule

// >>> hdl/dram_host_ctrl.sv
// Host controller that drives the strobe pins of a two-bank asynchronous DRAM module.
`timescale 1ns/1ps
// Notes on behaviour
// - Two banks; a bank is chosen only by dropping its own row strobes.
// - Each column strobe covers one byte lane plus its parity bit.
// - Page read: row held low, each column strobe fall reads a new column.
// - Page write: row held low, each column strobe fall writes a new column.
// - Row-only or column-first refresh, data pins never driven during refresh.
// - 1024 refreshes every 16 ms, one per timer slot.
// - Random cycle at least 130 ns, at most 128K ns.
// - Row strobe low in page mode at least 70 ns, at most 100K ns.
// - Page column accesses spaced at least 45 ns.
// - Row stays low at least 40 ns after last column precharge begins.
// - Column-first refresh: column strobes low 10 ns before row falls.
// - Column-first refresh: column strobes low 15 ns after row falls.
// - Column-first refresh: write strobe high 10 ns around row fall.
// - Write strobe stays high when a read's strobes rise.
// - Column precharge at least 10 ns between strobe edges.
// - Write strobe low at least 55 ns after row falls.
// - Write data stable at least 55 ns after row falls.
// - After power-up wait 100 us and issue 8 refreshes first.
module dram_host_ctrl #(
  parameter int INIT_CYC     = dram_host_pkg::INIT_PAUSE_CYC,
  parameter int RASP_MAX_CYC = dram_host_pkg::RASP_MAX_CYC_DFLT
) (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     en_i,
  input  wire logic                     refresh_cbr_i,
  input  wire logic                     req_valid_i,
  input  wire dram_host_pkg::mem_req_s  req_i,
  output logic                          req_ready_o,
  output logic                          rd_valid_o,
  output logic [35:0]                   rd_data_o,
  output logic                          init_done_o,
  output logic                          slow_grade_o,
  output dram_host_pkg::dram_pins_s     pins_o,
  input  wire logic [35:0]              dq_i,
  input  wire logic [3:0]               presence_detect_lines_i
);
  import dram_host_pkg::*;

  typedef struct packed {
    state_e      st;
    logic [13:0] cnt;
    logic [13:0] ras_cnt;
    logic [13:0] pc_cnt;
    logic [13:0] cpa_cnt;
    logic [3:0]  owed;
    logic [9:0]  ref_row;
    logic        init_done;
    logic        strobe;
    logic        wr;
    logic        bank;
    logic [9:0]  row;
    logic [9:0]  col;
    logic [3:0]  be;
    logic [35:0] wdata;
    dram_pins_s  pins;
    logic        rd_valid;
    logic [35:0] rd_data;
  } ctl_s;

  localparam logic [13:0] INIT_C   = 14'(INIT_CYC);
  localparam logic [13:0] PAGE_LIM = 14'(RASP_MAX_CYC) - PAGE_MARGIN_CYC;

  function automatic logic [3:0] bank_ras_n(input logic bank);
    return bank ? BANK1_RAS_N : BANK0_RAS_N;
  endfunction

  ctl_s        s;
  ctl_s        next_s;
  logic        rst_n;
  logic        ref_tick;
  logic [35:0] dq_s;
  logic [3:0]  pd_s;
  logic        page_hit;
  logic        page_limit;
  logic        page_ready;
  logic        accept;
  logic        read_ok;
  logic        write_done;
  logic        close_ok;

  sync2 #(.WIDTH(1)) u_rst_sync (
    .clk_i   (clk_i),
    .rst_n_i (nrst_i),
    .en_i    (1'b1),
    .d_i     (1'b1),
    .q_o     (rst_n)
  );

  sync2 #(.WIDTH(36)) u_dq_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .en_i    (en_i),
    .d_i     (dq_i),
    .q_o     (dq_s)
  );

  sync2 #(.WIDTH(4)) u_pd_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .en_i    (en_i),
    .d_i     (presence_detect_lines_i),
    .q_o     (pd_s)
  );

  refresh_timer u_refresh_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .en_i    (en_i),
    .tick_o  (ref_tick)
  );

  assign page_hit   = req_valid_i && (req_i.bank == s.bank) && (req_i.row == s.row);
  assign page_limit = s.ras_cnt >= PAGE_LIM;
  // A following write may only drive the bus once the device has let go of it.
  assign page_ready = (s.st == ST_PRE) && page_hit && (s.owed == 4'h0) && !page_limit &&
                      (s.cnt >= CP_CYC) && (s.cnt >= OFF_CYC) && (s.pc_cnt >= PC_CYC);
  // Refresh and the power-up sequence take priority over any request.
  assign req_ready_o = s.init_done && (s.owed == 4'h0) && ((s.st == ST_IDLE) || page_ready);
  assign accept      = req_valid_i && req_ready_o;
  assign read_ok     = (s.cnt >= CAC_CYC + DATA_LAT) && (s.cnt >= AA_CYC + DATA_LAT) &&
                       (s.ras_cnt >= RAC_CYC + DATA_LAT) && (s.cpa_cnt >= CPA_CYC + DATA_LAT);
  assign write_done  = (s.cnt >= CAS_CYC) && (s.cnt >= WCH_CYC) && (s.cnt >= DH_CYC) &&
                       (s.ras_cnt >= WCR_CYC) && (s.ras_cnt >= DHR_CYC);
  assign close_ok    = (s.cnt >= CPRH_CYC) && (s.ras_cnt >= RAS_CYC);

  always_comb begin
    next_s          = s;
    next_s.rd_valid = 1'b0;
    next_s.cnt      = sat_inc(s.cnt);
    next_s.ras_cnt  = sat_inc(s.ras_cnt);
    next_s.pc_cnt   = sat_inc(s.pc_cnt);
    next_s.cpa_cnt  = sat_inc(s.cpa_cnt);
    // A timer slot that lands on the retiring cycle of a refresh is still counted.
    if (ref_tick && (s.owed != OWED_MAX)) begin
      next_s.owed = s.owed + 4'h1;
    end
    unique case (s.st)
      ST_INIT: begin
        if (s.cnt >= INIT_C) begin
          next_s.st        = ST_IDLE;
          next_s.init_done = 1'b1;
          next_s.owed      = INIT_REFRESHES + {3'h0, ref_tick};
        end
      end
      ST_IDLE: begin
        if (s.owed != 4'h0) begin
          next_s.st                   = ST_REF;
          next_s.cnt                  = '0;
          next_s.pins.addr            = s.ref_row;
          next_s.pins.write_n         = 1'b1;
          next_s.pins.column_strobe_n = refresh_cbr_i ? 4'h0 : STROBES_OFF;
        end else if (accept) begin
          next_s.st        = ST_ROW;
          next_s.cnt       = '0;
          next_s.wr        = req_i.write;
          next_s.bank      = req_i.bank;
          next_s.row       = req_i.row;
          next_s.col       = req_i.col;
          next_s.be        = req_i.byte_en;
          next_s.wdata     = req_i.wdata;
          next_s.pins.addr = req_i.row;
        end
      end
      ST_REF: begin
        if (&s.pins.row_strobe_n) begin
          next_s.pins.row_strobe_n = 4'h0;
          next_s.ras_cnt           = '0;
          next_s.cnt               = '0;
        end else begin
          if (s.cnt >= CHR_CYC) begin
            next_s.pins.column_strobe_n = STROBES_OFF;
          end
          if (s.cnt >= RAS_CYC) begin
            next_s.st                   = ST_RP;
            next_s.cnt                  = '0;
            next_s.pins.row_strobe_n    = STROBES_OFF;
            next_s.pins.column_strobe_n = STROBES_OFF;
            next_s.owed                 = next_s.owed - 4'h1;
            next_s.ref_row              = s.ref_row + 10'h001;
          end
        end
      end
      ST_ROW: begin
        if (&s.pins.row_strobe_n) begin
          next_s.pins.row_strobe_n = bank_ras_n(s.bank);
          next_s.ras_cnt           = '0;
          next_s.cnt               = '0;
          next_s.cpa_cnt           = '1;
        end else begin
          if (s.cnt >= RAH_CYC) begin
            next_s.pins.addr = s.col;
          end
          // The fixed short strobe delay keeps reads inside the row access window.
          if (s.cnt >= RCD_CYC) begin
            next_s.st           = ST_COL;
            next_s.strobe       = 1'b0;
            next_s.pins.addr    = s.col;
            next_s.pins.write_n = !s.wr;
            next_s.pins.dq_oe_n = !s.wr;
            next_s.pins.dq      = s.wdata;
          end
        end
      end
      ST_COL: begin
        if (!s.strobe) begin
          next_s.strobe               = 1'b1;
          next_s.pins.column_strobe_n = s.wr ? ~s.be : 4'h0;
          next_s.cnt                  = '0;
          next_s.pc_cnt               = '0;
        end else if ((s.wr && write_done) || (!s.wr && read_ok)) begin
          if (!s.wr) begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data  = dq_s;
          end
          next_s.st                   = ST_PRE;
          next_s.cnt                  = '0;
          next_s.cpa_cnt              = '0;
          next_s.pins.column_strobe_n = STROBES_OFF;
          next_s.pins.write_n         = 1'b1;
          next_s.pins.dq_oe_n         = 1'b1;
        end
      end
      ST_PRE: begin
        if (accept) begin
          next_s.st           = ST_COL;
          next_s.strobe       = 1'b0;
          next_s.wr           = req_i.write;
          next_s.col          = req_i.col;
          next_s.be           = req_i.byte_en;
          next_s.wdata        = req_i.wdata;
          next_s.pins.addr    = req_i.col;
          next_s.pins.write_n = !req_i.write;
          next_s.pins.dq_oe_n = !req_i.write;
          next_s.pins.dq      = req_i.wdata;
        end else if (close_ok && ((s.owed != 4'h0) || page_limit || (req_valid_i && !page_hit))) begin
          next_s.st                = ST_RP;
          next_s.cnt               = '0;
          next_s.pins.row_strobe_n = STROBES_OFF;
        end
      end
      ST_RP: begin
        if ((s.cnt >= RP_CYC) && (s.ras_cnt >= RC_CYC)) begin
          next_s.st = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s                      <= '0;
      s.st                   <= ST_INIT;
      s.ras_cnt              <= '1;
      s.pc_cnt               <= '1;
      s.cpa_cnt              <= '1;
      s.pins.row_strobe_n    <= STROBES_OFF;
      s.pins.column_strobe_n <= STROBES_OFF;
      s.pins.write_n         <= 1'b1;
      s.pins.dq_oe_n         <= 1'b1;
    end else if (en_i) begin
      s <= next_s;
    end
  end

  assign pins_o       = s.pins;
  assign rd_valid_o   = s.rd_valid;
  assign rd_data_o    = s.rd_data;
  assign init_done_o  = s.init_done;
  assign slow_grade_o = ~pd_s[PD_GRADE_BIT];

  logic        ras_hi;
  logic        cas_hi;
  logic        ras_hi_q;
  logic        cas_hi_q;
  logic [13:0] ras_age;
  logic [13:0] cas_age;
  logic [13:0] cas_hi_run;

  assign ras_hi = &s.pins.row_strobe_n;
  assign cas_hi = &s.pins.column_strobe_n;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ras_hi_q   <= 1'b1;
      cas_hi_q   <= 1'b1;
      ras_age    <= '1;
      cas_age    <= '1;
      cas_hi_run <= '0;
    end else if (en_i) begin
      ras_hi_q   <= ras_hi;
      cas_hi_q   <= cas_hi;
      ras_age    <= (ras_hi_q && !ras_hi) ? 14'h0001 : sat_inc(ras_age);
      cas_age    <= (cas_hi_q && !cas_hi) ? 14'h0001 : sat_inc(cas_age);
      cas_hi_run <= cas_hi ? sat_inc(cas_hi_run) : 14'h0000;
    end
  end

  default clocking cb @(posedge clk_i iff en_i);
  endclocking
  default disable iff (!rst_n);

  a_bank_select: assert property ((s.st == ST_COL) |-> s.pins.row_strobe_n == bank_ras_n(s.bank))
    else $error("wrong bank strobes during column access");
  a_write_lanes: assert property ($fell(cas_hi) && !s.pins.write_n |-> s.pins.column_strobe_n == ~s.be)
    else $error("write lanes do not follow byte enables");
  a_read_float: assert property ($fell(cas_hi) && s.pins.write_n && !ras_hi |-> s.pins.dq_oe_n)
    else $error("bus driven during a read access");
  a_write_data: assert property ($fell(cas_hi) && !s.pins.write_n |-> !s.pins.dq_oe_n)
    else $error("write strobe without data driven");
  a_refresh_float: assert property ((s.st == ST_REF) |-> s.pins.dq_oe_n)
    else $error("bus driven during refresh");
  a_refresh_taken: assert property ((s.st == ST_IDLE) && (s.owed != 4'h0) |=> s.st == ST_REF)
    else $error("owed refresh not started");
  a_rc_min: assert property ($fell(ras_hi) |-> ras_age >= RC_CYC)
    else $error("random cycle too short");
  a_ras_width: assert property ($rose(ras_hi) |-> ras_age >= RAS_CYC)
    else $error("row strobe pulse too short");
  a_page_spacing: assert property ($fell(cas_hi) && !ras_hi |-> cas_age >= PC_CYC)
    else $error("column accesses too close");
  a_row_hold: assert property ($rose(ras_hi) |-> cas_hi_run >= CPRH_CYC)
    else $error("row released too soon after column precharge");
  a_cbr_setup: assert property ($fell(ras_hi) && !(|s.pins.column_strobe_n) |-> $past(s.pins.column_strobe_n) == 4'h0)
    else $error("column strobe setup before row missing");
  a_cbr_hold: assert property ($fell(ras_hi) && !(|s.pins.column_strobe_n) |-> (s.pins.column_strobe_n == 4'h0) [*2])
    else $error("column strobe hold after row too short");
  a_cbr_we: assert property ($fell(ras_hi) && !(|s.pins.column_strobe_n) |-> $past(s.pins.write_n) ##1 s.pins.write_n)
    else $error("write strobe low around refresh row fall");
  a_read_latency: assert property ($rose(s.rd_valid) |-> ras_age > RAC_CYC + DATA_LAT)
    else $error("read data taken before row access time");
  a_read_end: assert property ($rose(cas_hi) && s.pins.dq_oe_n |-> s.pins.write_n)
    else $error("write strobe low at end of read");
  a_write_hold: assert property ($rose(s.pins.write_n) |-> ras_age >= WCR_CYC)
    else $error("write strobe released too soon");
  a_data_hold: assert property ($rose(s.pins.dq_oe_n) |-> ras_age >= DHR_CYC)
    else $error("write data released too soon");
  a_init_gate: assert property (!s.init_done |-> !req_ready_o)
    else $error("request accepted before initialisation");
  a_no_drive_idle: assert property (ras_hi |-> s.pins.dq_oe_n)
    else $error("bus driven with row strobes high");

  c_read: cover property (s.rd_valid);
  c_write: cover property ($fell(cas_hi) && !s.pins.write_n);
  c_cbr: cover property ($fell(ras_hi) && !(|s.pins.column_strobe_n));
  c_page_hit: cover property ((s.st == ST_PRE) && accept);
endmodule

// >>> tb/dram_module_model.sv
// Behavioural model of the two-bank strobe-driven DRAM module.
`timescale 1ns/1ps
module dram_module_model #(
  parameter bit SLOW_GRADE = 1'b1
) (
  input  wire logic [3:0]  row_strobe_n_i,
  input  wire logic [3:0]  column_strobe_n_i,
  input  wire logic        write_n_i,
  input  wire logic [9:0]  addr_i,
  input  wire logic [35:0] dq_i,
  output logic      [35:0] dq_o,
  output logic      [3:0]  presence_detect_lines_o
);
  logic [35:0] mem [logic [20:0]];
  logic [9:0]  row_q [2];
  logic [3:0]  drive = 4'h0;
  logic [35:0] rdata = 36'h0;
  logic        flip = 1'b0;
  // A released bus keeps no value, so it toggles every half cycle instead.
  always #5 flip = ~flip;
  assign presence_detect_lines_o = {1'b1, ~SLOW_GRADE, 2'b11};
  // The row address is ignored when the column strobes are already low.
  always @(negedge row_strobe_n_i[0]) if (&column_strobe_n_i) row_q[0] = addr_i;
  always @(negedge row_strobe_n_i[1]) if (&column_strobe_n_i) row_q[1] = addr_i;
  for (genvar k = 0; k < 4; k++) begin : g_lane
    always @(negedge column_strobe_n_i[k]) begin
      automatic logic        b   = row_strobe_n_i[0];
      automatic logic [20:0] key = {b, row_q[b], addr_i};
      if (row_strobe_n_i[0] ^ row_strobe_n_i[1]) begin
        if (!write_n_i) begin
          if (!mem.exists(key)) mem[key] = 36'h0;
          mem[key][9*k+:9] = dq_i[9*k+:9];
        end else begin
          #20;
          if (!column_strobe_n_i[k]) begin
            rdata[9*k+:9] = mem.exists(key) ? mem[key][9*k+:9] : 9'h0;
            drive[k] = 1'b1;
          end
        end
      end
    end
    always @(posedge column_strobe_n_i[k] or posedge row_strobe_n_i[0] or posedge row_strobe_n_i[1])
      drive[k] = 1'b0;
    assign dq_o[9*k+:9] = drive[k] ? rdata[9*k+:9] : {9{flip}};
  end
endmodule

// >>> tb/dram_host_ctrl_tb_top.sv
// Self-checking bench for the DRAM module host controller.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module dram_host_ctrl_tb_top;
  import dram_host_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, column_first_refresh = 1'b0, valid = 1'b0, en = 1'b1;
  mem_req_s    req = '0;
  dram_pins_s  pins;
  logic        ready, rdv, done, slow;
  logic [35:0] rdata, dev_dq, bus;
  logic [3:0]  pd;
  int          n_mismatch = 0, total_checks = 0, cbr_seen = 0, rof_seen = 0;
  localparam logic [35:0] DA = 36'h123456789, DB = 36'h9abcdef01, DC = 36'h0f0f0f0f0;
  assign bus = pins.dq_oe_n ? dev_dq : pins.dq;
  dram_host_ctrl #(.INIT_CYC(20), .RASP_MAX_CYC(200)) DUT (
    .clk_i(clk), .nrst_i(nrst), .en_i(en), .refresh_cbr_i(column_first_refresh), .req_valid_i(valid),
    .req_i(req), .req_ready_o(ready), .rd_valid_o(rdv), .rd_data_o(rdata), .init_done_o(done),
    .slow_grade_o(slow), .pins_o(pins), .dq_i(bus), .presence_detect_lines_i(pd));
  dram_module_model #(.SLOW_GRADE(1'b1)) device (
    .row_strobe_n_i(pins.row_strobe_n), .column_strobe_n_i(pins.column_strobe_n),
    .write_n_i(pins.write_n), .addr_i(pins.addr), .dq_i(bus), .dq_o(dev_dq),
    .presence_detect_lines_o(pd));
  initial forever #5 clk = ~clk;
  always @(negedge pins.row_strobe_n[0]) begin
    if (pins.row_strobe_n === 4'h0 && pins.column_strobe_n === 4'h0) cbr_seen++;
    if (pins.row_strobe_n === 4'h0 && pins.column_strobe_n === 4'hf) rof_seen++;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic send(input mem_req_s r);
    int i;
    @(negedge clk);
    req = r;
    valid = 1'b1;
    // Ready depends on the request itself, so let it settle before it is looked at.
    #1;
    for (i = 0; i < 3000 && ready !== 1'b1; i++) @(negedge clk) #1;
    if (i == 3000) begin n_mismatch++; conclude(); end
    @(negedge clk);
    valid = 1'b0;
  endtask
  task automatic wr(input logic b, input logic [9:0] r, c, input logic [3:0] be, input logic [35:0] d);
    send('{1'b1, b, r, c, be, d});
  endtask
  task automatic rd(input logic b, input logic [9:0] r, c, input logic [35:0] exp);
    int i;
    send('{1'b0, b, r, c, 4'hf, 36'h0});
    for (i = 0; i < 60 && rdv !== 1'b1; i++) @(negedge clk);
    if (i == 60) begin n_mismatch++; conclude(); end
    `CHK(rdata, exp)
  endtask
  task automatic t_page;
    wr(1'b0, 10'h012, 10'h003, 4'hf, DA);
    wr(1'b0, 10'h012, 10'h004, 4'hf, DB);
    rd(1'b0, 10'h012, 10'h003, DA);
    rd(1'b0, 10'h012, 10'h004, DB);
    `CHK(pins.write_n, 1'b1)
  endtask
  task automatic t_banks;
    wr(1'b1, 10'h012, 10'h003, 4'hf, DC);
    rd(1'b1, 10'h012, 10'h003, DC);
    rd(1'b0, 10'h012, 10'h003, DA);
  endtask
  task automatic t_freeze;
    dram_pins_s p;
    int i;
    send('{1'b0, 1'b1, 10'h012, 10'h003, 4'hf, 36'h0});
    en = 1'b0;
    p = pins;
    repeat (20) @(negedge clk);
    `CHK(pins, p)
    `CHK(rdv, 1'b0)
    en = 1'b1;
    for (i = 0; i < 60 && rdv !== 1'b1; i++) @(negedge clk);
    if (i == 60) begin n_mismatch++; conclude(); end
    `CHK(rdata, DC)
  endtask
  task automatic t_lanes;
    wr(1'b0, 10'h012, 10'h003, 4'h2, 36'hfffffffff);
    rd(1'b0, 10'h012, 10'h003, {DA[35:18], 9'h1ff, DA[8:0]});
  endtask
  task automatic t_refresh;
    `CHK(rof_seen >= 8, 1'b1)
    column_first_refresh = 1'b1;
    repeat (1700) @(negedge clk);
    `CHK(cbr_seen > 0, 1'b1)
    `CHK(pins.dq_oe_n, 1'b1)
    wr(1'b0, 10'h020, 10'h005, 4'hf, DB);
    rd(1'b0, 10'h012, 10'h004, DB);
    rd(1'b0, 10'h020, 10'h005, DB);
  endtask
  initial begin
    int i;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    for (i = 0; i < 500 && done !== 1'b1; i++) @(negedge clk);
    if (i == 500) begin n_mismatch++; conclude(); end
    `CHK(slow, 1'b1)
    t_page();
    t_banks();
    t_freeze();
    t_lanes();
    t_refresh();
    conclude();
  end
endmodule
